// ---- logic/sccpp_pkg.sv ----
// Shared constants, command codes and CRC8 for the power information link
package sccpp_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CW = 21;

  // Line timing in microseconds
  localparam int RST_LOW_US = 10000;
  localparam int RST_DET_US = 5000;
  localparam int RST_HIGH_US = 2000;
  localparam int SLOT_US = 4000;
  localparam int W1L_US = 100;
  localparam int W0L_US = 2000;
  localparam int RDL_US = 100;
  localparam int RD_SAMPLE_US = 1200;
  localparam int WR_SAMPLE_US = 1100;
  localparam int HOLD0_US = 2500;

  // Same timing in clock cycles
  localparam logic [CW-1:0] RST_LOW_CYC = CW'(RST_LOW_US * CLK_MHZ);
  localparam logic [CW-1:0] RST_DET_CYC = CW'(RST_DET_US * CLK_MHZ);
  localparam logic [CW-1:0] RST_HIGH_CYC = CW'(RST_HIGH_US * CLK_MHZ);
  localparam logic [CW-1:0] SLOT_CYC = CW'(SLOT_US * CLK_MHZ);
  localparam logic [CW-1:0] W1L_CYC = CW'(W1L_US * CLK_MHZ);
  localparam logic [CW-1:0] W0L_CYC = CW'(W0L_US * CLK_MHZ);
  localparam logic [CW-1:0] RDL_CYC = CW'(RDL_US * CLK_MHZ);
  localparam logic [CW-1:0] RD_SAMPLE_CYC = CW'(RD_SAMPLE_US * CLK_MHZ);
  localparam logic [CW-1:0] WR_SAMPLE_CYC = CW'(WR_SAMPLE_US * CLK_MHZ);
  localparam logic [CW-1:0] HOLD0_CYC = CW'(HOLD0_US * CLK_MHZ);

  // Address and command bytes
  localparam logic [7:0] ADDR_BCAST = 8'hA0;
  localparam logic [7:0] CMD_VOLT_RD = 8'hA1;
  localparam logic [7:0] CMD_PREQ_RD = 8'hA2;
  localparam logic [7:0] CMD_GRANT_WR = 8'hA3;
  localparam logic [7:0] CMD_GRANT_RD = 8'hA4;

  // Frame layout and values
  localparam int BYTE_BITS = 8;
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS = 16;
  localparam int WR_BITS = 40;
  localparam logic [23:0] FRAME_ONES = 24'hFFFFFF;
  localparam logic [11:0] PREQ_MIN = 12'h004;
  localparam logic [11:0] GRANT_RST = 12'h000;
  localparam logic [7:0] VOLT_RST = 8'h00;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h8C;

  // Reflected CRC8, data taken least significant bit first
  function automatic logic [7:0] crc8(input logic [15:0] data);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 16; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction
endpackage

// ---- logic/sccpp_line_if.sv ----
// Single-wire open-drain line joining the sourcing end and the device end
`timescale 1ns/1ps
interface sccpp_line_if;
  logic pse_o;
  logic pse_oe_n;
  logic pd_o;
  logic pd_oe_n;
  logic line;

  // Wired-AND with pull-up: any enabled low driver wins
  assign line = (pse_oe_n | pse_o) & (pd_oe_n | pd_o);

  modport pse (output pse_o, output pse_oe_n, input line);
  modport pd (output pd_o, output pd_oe_n, input line);
endinterface

// ---- logic/sccpp_pd.sv ----
// Device end: answers voltage, power request and power grant commands on the line
// Operation
// - Accept voltage, request, grant write, grant read
// - Reads answer 16-bit payload then CRC8
// - Voltage unit is 10 mV, 8 bits
// - Reported voltage never over 20 mV high
// - Voltage payload upper byte zero
// - Voltage latched during line initialization
// - Request in bits 11:0, 0.025 W units
// - Request and grant bits 15:12 zero
// - Request between 0.1 W and class limit
// - Grant write: payload then CRC8 received
// - Sourcing end zeroes grant bits 15:12 (sccpp_pse sends wr_payload bits 15:12 unchanged)
// - Grant read returns last written grant
// - Reset pulse, broadcast address, then command
// - Sourcing end starts 24 read slots
// - Sourcing end sends 16 payload slots, CRC
// - Every field least significant bit first
// - Unsupported command returns all ones
// - One leaves line high, zero pulls low
// - Write slot sampled fixed time after fall
`timescale 1ns/1ps
module sccpp_pd #(
  parameter logic [sccpp_pkg::CW-1:0] RST_DET_CYC = sccpp_pkg::RST_DET_CYC,
  parameter logic [sccpp_pkg::CW-1:0] WR_SAMPLE_CYC = sccpp_pkg::WR_SAMPLE_CYC,
  parameter logic [sccpp_pkg::CW-1:0] HOLD0_CYC = sccpp_pkg::HOLD0_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Line
  sccpp_line_if.pd line_if,
  // Measurements and settings at the power interface
  input wire logic [7:0] volt_code,
  input wire logic [11:0] power_request,
  input wire logic [11:0] class_power_limit,
  // Grant seen by local power management
  output logic [11:0] power_grant,
  output logic grant_strobe
);

  typedef enum logic [2:0] {
    SCCPP_IDLE,
    SCCPP_ADDR,
    SCCPP_CMD,
    SCCPP_RECV,
    SCCPP_SEND
  } sccpp_pd_state_t;

  sccpp_pd_state_t state_q, state_d;
  logic sync1_q, sync2_q, prev_q;
  logic [sccpp_pkg::CW-1:0] low_t_q, low_t_d;
  logic [sccpp_pkg::CW-1:0] slot_t_q, slot_t_d;
  logic slot_act_q, slot_act_d;
  logic [4:0] bits_q, bits_d;
  logic [23:0] sh_q, sh_d;
  logic [7:0] volt_q, volt_d;
  logic [11:0] grant_q, grant_d;
  logic strobe_q, strobe_d;
  logic oe_n_q, oe_n_d;
  logic drv_q;
  logic fall, rise;
  logic [7:0] byte_in;
  logic [23:0] word_in;

  // Request clamped into the legal window for the class
  function automatic logic [11:0] clamp_req(input logic [11:0] req, input logic [11:0] lim);
    logic [11:0] r;
    r = req;
    if (r < sccpp_pkg::PREQ_MIN) begin
      r = sccpp_pkg::PREQ_MIN;
    end else if (r > lim) begin
      r = lim;
    end
    return r;
  endfunction

  // Payload followed by its CRC8, ready to shift out from bit 0
  function automatic logic [23:0] frame(input logic [15:0] payload);
    return {sccpp_pkg::crc8(payload), payload};
  endfunction

  assign fall = prev_q & ~sync2_q;
  assign rise = ~prev_q & sync2_q;
  // Bits arrive at the top and move down, so the first one ends at bit 0
  assign byte_in = {sync2_q, sh_q[23:17]};
  assign word_in = {sync2_q, sh_q[23:1]};

  assign line_if.pd_o = drv_q;
  assign line_if.pd_oe_n = oe_n_q;
  assign power_grant = grant_q;
  assign grant_strobe = strobe_q;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      sync1_q <= line_if.line;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  always_comb begin
    state_d = state_q;
    slot_t_d = slot_t_q;
    slot_act_d = slot_act_q;
    bits_d = bits_q;
    sh_d = sh_q;
    volt_d = volt_q;
    grant_d = grant_q;
    strobe_d = 1'b0;
    oe_n_d = oe_n_q;
    low_t_d = low_t_q;

    // Continuous low time, saturating, tells a reset pulse from a slot
    if (sync2_q) begin
      low_t_d = '0;
    end else if (low_t_q != RST_DET_CYC) begin
      low_t_d = low_t_q + 1'b1;
    end

    // Every falling edge outside SCCPP_IDLE opens a slot; its timer stops once the slot is served
    if (fall) begin
      slot_t_d = '0;
      slot_act_d = 1'b1;
    end else if (slot_act_q) begin
      slot_t_d = slot_t_q + 1'b1;
    end

    if (rise && low_t_q == RST_DET_CYC) begin
      // Reset pulse ended: capture supply level while the line rests high
      state_d = SCCPP_ADDR;
      volt_d = volt_code;
      bits_d = '0;
      sh_d = '0;
      slot_act_d = 1'b0;
      oe_n_d = 1'b1;
    end else begin
      case (state_q)
        SCCPP_ADDR, SCCPP_CMD, SCCPP_RECV: begin
          if (slot_act_q && slot_t_q == WR_SAMPLE_CYC) begin
            slot_act_d = 1'b0;
            sh_d = word_in;
            bits_d = bits_q + 1'b1;
            if (state_q == SCCPP_ADDR && bits_q == 5'(sccpp_pkg::BYTE_BITS - 1)) begin
              bits_d = '0;
              if (byte_in == sccpp_pkg::ADDR_BCAST) begin
                state_d = SCCPP_CMD;
              end else begin
                state_d = SCCPP_SEND;
                sh_d = sccpp_pkg::FRAME_ONES;
              end
            end else if (state_q == SCCPP_CMD && bits_q == 5'(sccpp_pkg::BYTE_BITS - 1)) begin
              bits_d = '0;
              state_d = SCCPP_SEND;
              case (byte_in)
                sccpp_pkg::CMD_VOLT_RD: begin
                  // Supply reading must be truncated, never rounded up, upstream
                  sh_d = frame({8'h00, volt_q});
                end
                sccpp_pkg::CMD_PREQ_RD: begin
                  sh_d = frame({4'h0, clamp_req(power_request, class_power_limit)});
                end
                sccpp_pkg::CMD_GRANT_RD: begin
                  sh_d = frame({4'h0, grant_q});
                end
                sccpp_pkg::CMD_GRANT_WR: begin
                  state_d = SCCPP_RECV;
                  sh_d = '0;
                end
                default: begin
                  sh_d = sccpp_pkg::FRAME_ONES;
                end
              endcase
            end else if (state_q == SCCPP_RECV && bits_q == 5'(sccpp_pkg::FRAME_BITS - 1)) begin
              bits_d = '0;
              state_d = SCCPP_IDLE;
              // Upper payload nibble is not checked; only the grant field is kept
              if (sccpp_pkg::crc8(word_in[15:0]) == word_in[23:16]) begin
                grant_d = word_in[11:0];
                strobe_d = 1'b1;
              end
            end
          end
        end
        SCCPP_SEND: begin
          if (fall) begin
            oe_n_d = sh_q[0];
            sh_d = {1'b1, sh_q[23:1]};
            bits_d = bits_q + 1'b1;
          end else if (slot_act_q && slot_t_q == HOLD0_CYC) begin
            // A zero is held past the sampling point, then released
            oe_n_d = 1'b1;
            slot_act_d = 1'b0;
            if (bits_q == 5'(sccpp_pkg::FRAME_BITS)) begin
              state_d = SCCPP_IDLE;
              bits_d = '0;
            end
          end
        end
        default: begin
          slot_act_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= SCCPP_IDLE;
      low_t_q <= '0;
      slot_t_q <= '0;
      slot_act_q <= 1'b0;
      bits_q <= '0;
      sh_q <= '0;
      volt_q <= sccpp_pkg::VOLT_RST;
      grant_q <= sccpp_pkg::GRANT_RST;
      strobe_q <= 1'b0;
      oe_n_q <= 1'b1;
      drv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      low_t_q <= low_t_d;
      slot_t_q <= slot_t_d;
      slot_act_q <= slot_act_d;
      bits_q <= bits_d;
      sh_q <= sh_d;
      volt_q <= volt_d;
      grant_q <= grant_d;
      strobe_q <= strobe_d;
      oe_n_q <= oe_n_d;
      drv_q <= 1'b0;
    end
  end

endmodule

// ---- logic/sccpp_pse.sv ----
// Sourcing end: issues reset, broadcast address, command and slots on the line
`timescale 1ns/1ps
module sccpp_pse #(
  parameter logic [sccpp_pkg::CW-1:0] RST_LOW_CYC = sccpp_pkg::RST_LOW_CYC,
  parameter logic [sccpp_pkg::CW-1:0] RST_HIGH_CYC = sccpp_pkg::RST_HIGH_CYC,
  parameter logic [sccpp_pkg::CW-1:0] SLOT_CYC = sccpp_pkg::SLOT_CYC,
  parameter logic [sccpp_pkg::CW-1:0] W1L_CYC = sccpp_pkg::W1L_CYC,
  parameter logic [sccpp_pkg::CW-1:0] W0L_CYC = sccpp_pkg::W0L_CYC,
  parameter logic [sccpp_pkg::CW-1:0] RDL_CYC = sccpp_pkg::RDL_CYC,
  parameter logic [sccpp_pkg::CW-1:0] RD_SAMPLE_CYC = sccpp_pkg::RD_SAMPLE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Line
  sccpp_line_if.pse line_if,
  // Command request
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] wr_payload,
  output logic busy,
  // Read answer
  output logic rsp_valid,
  output logic [15:0] rsp_payload,
  output logic rsp_crc_ok
);

  typedef enum logic [1:0] {
    SCCPP_P_IDLE,
    SCCPP_P_RST_LO,
    SCCPP_P_RST_HI,
    SCCPP_P_SLOT
  } sccpp_pse_state_t;

  sccpp_pse_state_t state_q, state_d;
  logic sync1_q, sync2_q;
  logic [sccpp_pkg::CW-1:0] t_q, t_d;
  logic [5:0] bit_q, bit_d;
  logic [39:0] tx_q, tx_d;
  logic [23:0] rx_q, rx_d;
  logic wr_q, wr_d;
  logic oe_n_q, oe_n_d;
  logic busy_q, busy_d;
  logic vld_q, vld_d;
  logic [15:0] pay_q, pay_d;
  logic ok_q, ok_d;
  logic drv_q;
  logic rd_phase;
  logic [sccpp_pkg::CW-1:0] low_len;
  logic [5:0] last_bit;

  assign rd_phase = !wr_q && bit_q >= 6'(sccpp_pkg::HDR_BITS);
  assign low_len = rd_phase ? RDL_CYC : (tx_q[0] ? W1L_CYC : W0L_CYC);
  assign last_bit = wr_q ? 6'(sccpp_pkg::WR_BITS - 1) : 6'(sccpp_pkg::HDR_BITS + sccpp_pkg::FRAME_BITS - 1);

  assign line_if.pse_o = drv_q;
  assign line_if.pse_oe_n = oe_n_q;
  assign busy = busy_q;
  assign rsp_valid = vld_q;
  assign rsp_payload = pay_q;
  assign rsp_crc_ok = ok_q;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= line_if.line;
      sync2_q <= sync1_q;
    end
  end

  always_comb begin
    state_d = state_q;
    t_d = t_q + 1'b1;
    bit_d = bit_q;
    tx_d = tx_q;
    rx_d = rx_q;
    wr_d = wr_q;
    oe_n_d = oe_n_q;
    busy_d = busy_q;
    vld_d = 1'b0;
    pay_d = pay_q;
    ok_d = ok_q;
    case (state_q)
      SCCPP_P_IDLE: begin
        t_d = '0;
        if (cmd_valid) begin
          wr_d = (cmd_code == sccpp_pkg::CMD_GRANT_WR);
          // Address, command, payload, CRC: shifted out from bit 0; payload and CRC reach the line only for grant write
          tx_d = {sccpp_pkg::crc8(wr_payload), wr_payload, cmd_code, sccpp_pkg::ADDR_BCAST};
          busy_d = 1'b1;
          oe_n_d = 1'b0;
          state_d = SCCPP_P_RST_LO;
        end
      end
      SCCPP_P_RST_LO: begin
        if (t_q == RST_LOW_CYC - 1'b1) begin
          t_d = '0;
          oe_n_d = 1'b1;
          state_d = SCCPP_P_RST_HI;
        end
      end
      SCCPP_P_RST_HI: begin
        if (t_q == RST_HIGH_CYC - 1'b1) begin
          t_d = '0;
          bit_d = '0;
          oe_n_d = 1'b0;
          state_d = SCCPP_P_SLOT;
        end
      end
      default: begin
        if (t_q == low_len) begin
          oe_n_d = 1'b1;
        end
        if (rd_phase && t_q == RD_SAMPLE_CYC) begin
          rx_d = {sync2_q, rx_q[23:1]};
        end
        if (t_q == SLOT_CYC - 1'b1) begin
          t_d = '0;
          tx_d = {1'b1, tx_q[39:1]};
          bit_d = bit_q + 1'b1;
          if (bit_q == last_bit) begin
            state_d = SCCPP_P_IDLE;
            busy_d = 1'b0;
            vld_d = !wr_q;
            pay_d = rx_q[15:0];
            ok_d = (sccpp_pkg::crc8(rx_q[15:0]) == rx_q[23:16]);
          end else begin
            oe_n_d = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= SCCPP_P_IDLE;
      t_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      wr_q <= 1'b0;
      oe_n_q <= 1'b1;
      busy_q <= 1'b0;
      vld_q <= 1'b0;
      pay_q <= '0;
      ok_q <= 1'b0;
      drv_q <= 1'b0;
    end else begin
      state_q <= state_d;
      t_q <= t_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      wr_q <= wr_d;
      oe_n_q <= oe_n_d;
      busy_q <= busy_d;
      vld_q <= vld_d;
      pay_q <= pay_d;
      ok_q <= ok_d;
      drv_q <= 1'b0;
    end
  end

endmodule

// ---- tb/sccpp_line_asserts.sv ----
// Line-level checks between the sourcing end and the device end
`timescale 1ns/1ps
module sccpp_line_asserts #(
  parameter int RST_LOW = 400,
  parameter int RST_HIGH = 80,
  parameter int SLOT = 160,
  parameter int W1L = 4,
  parameter int W0L = 80,
  parameter int HOLD0 = 100
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Line drivers and wire
  input wire logic pse_o,
  input wire logic pse_oe_n,
  input wire logic pd_o,
  input wire logic pd_oe_n,
  input wire logic line
);
  logic [15:0] pl_q;
  logic [15:0] ph_q;
  logic [15:0] lo_q;
  logic [15:0] sf_q;
  logic [15:0] last_q;
  logic [7:0] slots_q;

  // High run and slot-start counts saturate so a long idle never wraps into a false short run
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pl_q <= 16'h0000;
      ph_q <= 16'hFFFF;
      lo_q <= 16'h0000;
      sf_q <= 16'hFFFF;
      last_q <= 16'h0000;
      slots_q <= 8'h00;
    end else begin
      pl_q <= pse_oe_n ? 16'h0000 : pl_q + 16'h0001;
      ph_q <= !pse_oe_n ? 16'h0000 : ((ph_q == 16'hFFFF) ? ph_q : ph_q + 16'h0001);
      lo_q <= pd_oe_n ? 16'h0000 : lo_q + 16'h0001;
      sf_q <= (!pse_oe_n && pl_q == 16'h0000) ? 16'h0001 : ((sf_q == 16'hFFFF) ? sf_q : sf_q + 16'h0001);
      if (pse_oe_n && pl_q != 16'h0000) begin
        last_q <= pl_q;
        slots_q <= (pl_q >= RST_LOW) ? 8'h00 : slots_q + 8'h01;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  property p_pd_open_drain; pd_o == 1'b0; endproperty
  a_pd_open_drain: assert property (p_pd_open_drain) else $error("device drives the line high");
  property p_pd_zero_start; $fell(pd_oe_n) |-> sf_q >= 2 && sf_q <= 8; endproperty
  a_pd_zero_start: assert property (p_pd_zero_start) else $error("device pull not tied to slot start");
  // The device sees the slot three cycles late and releases one cycle after its hold count matches
  property p_pd_zero_hold; $rose(pd_oe_n) |-> lo_q >= HOLD0 && lo_q <= HOLD0 + 1; endproperty
  a_pd_zero_hold: assert property (p_pd_zero_hold) else $error("device zero held wrong length");
  property p_pd_no_stuck; lo_q <= HOLD0 + 1; endproperty
  a_pd_no_stuck: assert property (p_pd_no_stuck) else $error("device holds line too long");
  property p_pd_quiet_long; pl_q >= W0L + 4 |-> pd_oe_n; endproperty
  a_pd_quiet_long: assert property (p_pd_quiet_long) else $error("device drives during reset pulse");
  property p_pse_low_kinds;
    $rose(pse_oe_n) |-> pl_q <= W1L + 2 || (pl_q >= W0L && pl_q <= W0L + 2) || pl_q >= RST_LOW;
  endproperty
  a_pse_low_kinds: assert property (p_pse_low_kinds) else $error("sourcing low of unknown length");
  property p_pse_reset_gap; $fell(pse_oe_n) && last_q >= RST_LOW |-> ph_q >= RST_HIGH - 1; endproperty
  a_pse_reset_gap: assert property (p_pse_reset_gap) else $error("slot too soon after reset");
  property p_pse_slot_period; $fell(pse_oe_n) && last_q < RST_LOW |-> last_q + ph_q >= SLOT - 2; endproperty
  a_pse_slot_period: assert property (p_pse_slot_period) else $error("slots closer than one period");
  property p_pse_frame_slots; $rose(pse_oe_n) && pl_q >= RST_LOW |-> slots_q == 0 || slots_q == 40; endproperty
  a_pse_frame_slots: assert property (p_pse_frame_slots) else $error("frame slot count wrong");

  c_zero_bit: cover property ($rose(pd_oe_n) && line);
  c_reset_pulse: cover property ($rose(pse_oe_n) && pl_q >= RST_LOW);
  c_full_frame: cover property (slots_q == 8'h28);
endmodule

// ---- tb/sccp_power_info_commands_tb_top.sv ----
// Both ends joined over the line, exercised through command transfers
`timescale 1ns/1ps
module sccp_power_info_commands_tb_top;
  localparam int CW = sccpp_pkg::CW;
  localparam int RST_LOW = 400;
  localparam int RST_HIGH = 80;
  localparam int SLOT = 160;
  localparam int W1L = 4;
  localparam int W0L = 80;
  localparam int HOLD0 = 100;
  localparam int RDL = 4;
  localparam int RST_DET = 200;
  localparam int RD_SMP = 48;
  localparam int WR_SMP = 44;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] wr_payload = 16'h0000;
  logic [7:0] volt_code = 8'h00;
  logic [11:0] power_request = 12'h000;
  logic [11:0] class_power_limit = 12'h000;
  logic busy;
  logic rsp_valid;
  logic rsp_crc_ok;
  logic grant_strobe;
  logic [15:0] rsp_payload;
  logic [11:0] power_grant;
  logic [15:0] got_p;
  logic got_c;
  int n_errors = 0;
  int checks_done = 0;
  int n_rsp;
  int n_stb;
  // Request, class limit, expected clamped value
  logic [35:0] preq [3] = '{36'h002100004, 36'hFFF0C80C8, 36'h050100050};
  // Grant payloads keep bits 15:12 clear, as the sourcing end must send them
  logic [15:0] gw [3] = '{16'h0000, 16'h0456, 16'h0123};

  sccpp_line_if line_if ();
  always #5 ref_clk = ~ref_clk;

  sccpp_pse #(.RST_LOW_CYC(RST_LOW[CW-1:0]), .RST_HIGH_CYC(RST_HIGH[CW-1:0]), .SLOT_CYC(SLOT[CW-1:0]),
    .W1L_CYC(W1L[CW-1:0]), .W0L_CYC(W0L[CW-1:0]), .RDL_CYC(RDL[CW-1:0]), .RD_SAMPLE_CYC(RD_SMP[CW-1:0]))
    sccpp_pse_i (.ref_clk(ref_clk), .reset_n(reset_n), .line_if(line_if), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .wr_payload(wr_payload), .busy(busy), .rsp_valid(rsp_valid),
    .rsp_payload(rsp_payload), .rsp_crc_ok(rsp_crc_ok));
  sccpp_pd #(.RST_DET_CYC(RST_DET[CW-1:0]), .WR_SAMPLE_CYC(WR_SMP[CW-1:0]), .HOLD0_CYC(HOLD0[CW-1:0]))
    sccpp_pd_i (.ref_clk(ref_clk), .reset_n(reset_n), .line_if(line_if), .volt_code(volt_code),
    .power_request(power_request), .class_power_limit(class_power_limit), .power_grant(power_grant),
    .grant_strobe(grant_strobe));
  sccpp_line_asserts #(.RST_LOW(RST_LOW), .RST_HIGH(RST_HIGH), .SLOT(SLOT), .W1L(W1L), .W0L(W0L), .HOLD0(HOLD0))
    sccpp_line_asserts_i (.ref_clk(ref_clk), .reset_n(reset_n), .pse_o(line_if.pse_o),
    .pse_oe_n(line_if.pse_oe_n), .pd_o(line_if.pd_o), .pd_oe_n(line_if.pd_oe_n), .line(line_if.line));

  // Own reference so the expectation does not lean on the design's helper
  function automatic logic [7:0] crc_ref(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 16; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    return c;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] act);
    checks_done++;
    if (act !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, act);
    end
  endtask

  // One whole frame; returns once busy has stayed low for a few cycles
  task automatic xfer(input logic [7:0] code, input logic [15:0] wd);
    int n;
    int idle;
    n = 0;
    idle = 0;
    n_rsp = 0;
    n_stb = 0;
    cmd_code = code;
    wr_payload = wd;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (idle < 4 && n < 8000) begin
      @(negedge ref_clk);
      n++;
      idle = (busy === 1'b0) ? idle + 1 : 0;
      if (rsp_valid === 1'b1) begin
        n_rsp++;
        got_p = rsp_payload;
        got_c = rsp_crc_ok;
      end
      if (grant_strobe === 1'b1) n_stb++;
    end
    check("frame end", 16'h0000, {15'h0000, n >= 8000});
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    volt_code = 8'hA5;
    class_power_limit = 12'h100;
    // Reading moves after the reset pulse; the latched value must be reported
    fork
      xfer(sccpp_pkg::CMD_VOLT_RD, 16'h0000);
      begin
        repeat (RST_LOW + 2 * RST_HIGH) @(negedge ref_clk);
        volt_code = 8'h3C;
      end
    join
    check("volt payload", 16'h00A5, got_p);
    check("volt crc", 16'h0001, {15'h0000, got_c});
    check("volt answers", 16'h0001, n_rsp[15:0]);
    $display("test volt done");
    for (int i = 0; i < 3; i++) begin
      power_request = preq[i][35:24];
      class_power_limit = preq[i][23:12];
      xfer(sccpp_pkg::CMD_PREQ_RD, 16'h0000);
      check("request payload", {4'h0, preq[i][11:0]}, got_p);
      check("request crc", 16'h0001, {15'h0000, got_c});
    end
    $display("test request done");
    for (int i = 0; i < 3; i++) begin
      if (i > 0) begin
        xfer(sccpp_pkg::CMD_GRANT_WR, gw[i]);
        check("grant strobes", 16'h0001, n_stb[15:0]);
        check("write answers", 16'h0000, n_rsp[15:0]);
        check("grant out", {4'h0, gw[i][11:0]}, {4'h0, power_grant});
      end
      xfer(sccpp_pkg::CMD_GRANT_RD, 16'h0000);
      check("grant read", {4'h0, gw[i][11:0]}, got_p);
      check("grant crc", 16'h0001, {15'h0000, got_c});
    end
    $display("test grant done");
    xfer(8'h55, 16'h0000);
    check("unknown payload", 16'hFFFF, got_p);
    check("unknown crc", {15'h0000, crc_ref(16'hFFFF) == 8'hFF}, {15'h0000, got_c});
    check("grant kept", 16'h0123, {4'h0, power_grant});
    $display("test unknown done");
    results();
  end

  initial begin
    #900000;
    n_errors++;
    $display("[ERR] watchdog expected done seen hang");
    results();
  end
endmodule
